// ==== pkg/sps_defs.svh ====
// Constants of the serial port engine
`ifndef SPS_DEFS_SVH
`define SPS_DEFS_SVH
`define SPS_MODE_DIV4 4'h0
`define SPS_MODE_DIV16 4'h1
`define SPS_MODE_DIV64 4'h2
`define SPS_MODE_TMR 4'h3
`define SPS_MODE_SLV_SS 4'h4
`define SPS_MODE_SLV 4'h5
`define SPS_MODE_RELOAD 4'ha
`define SPS_HALF_DIV4 10'h002
`define SPS_HALF_DIV16 10'h008
`define SPS_HALF_DIV64 10'h020
`define SPS_DIV_ONE 10'h001
`define SPS_DIV_ZERO 10'h000
`define SPS_LAST_BIT 3'h7
`define SPS_BIT_ZERO 3'h0
`define SPS_BIT_ONE 3'h1
`define SPS_LAST_PHASE 4'hf
`define SPS_PHASE_ZERO 4'h0
`define SPS_PHASE_ONE 4'h1
`define SPS_BYTE_ZERO 8'h00
`define SPS_FIFO_W 8
`define SPS_FIFO_D 32
`endif

// ==== pkg/sps_pkg.sv ====
// Types of the serial port engine
`default_nettype none
package sps_pkg;
    typedef enum logic [1:0] {
        SPS_IDLE = 2'b00,
        SPS_RUN = 2'b01,
        SPS_TAIL = 2'b11
    } sps_mst_t;
    typedef struct packed {
        logic en;
        logic [3:0] mode;
        logic cpol;
        logic cke;
        logic sample_phase_bit;
        logic buffer_overwrite_enable;
        logic [7:0] reload;
    } sps_cfg_t;
    typedef struct packed {
        logic bf;
        logic irq;
        logic write_collision_flag;
        logic busy;
    } sps_flags_t;
endpackage : sps_pkg
`default_nettype wire

// ==== verilog/sps_sync.sv ====
// Two-flop synchroniser for pin inputs
`default_nettype none
module sps_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : sps_sync
`default_nettype wire

// ==== verilog/sps_fifo.sv ====
// Receive FIFO with registered full and empty
`default_nettype none
module sps_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] cnt;
    logic [AW:0] next_cnt;
    logic full;
    logic push;
    logic pop;
    assign push = in_valid && !full;
    assign pop = out_valid && out_ready;
    assign in_ready = !full;
    assign out_data = mem[rd_ptr];
    always_comb begin
        next_cnt = cnt;
        if (push && !pop) next_cnt = cnt + 1'b1;
        if (pop && !push) next_cnt = cnt - 1'b1;
    end
    always_ff @(posedge ref_clk) begin
        if (push) mem[wr_ptr] <= in_data;
    end
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            cnt <= '0;
            full <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            if (push) wr_ptr <= wr_ptr + 1'b1;
            if (pop) rd_ptr <= rd_ptr + 1'b1;
            cnt <= next_cnt;
            full <= (next_cnt == (AW+1)'(D));
            out_valid <= (next_cnt != '0);
        end
    end
endmodule : sps_fifo
`default_nettype wire

// ==== verilog/sps_port.sv ====
// SPI engine of the synchronous serial port
`include "sps_defs.svh"
`default_nettype none
module sps_port (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Configuration
    input wire sps_pkg::sps_cfg_t cfg,
    input wire logic sdo_disable,
    input wire logic tmr_tick,
    // Software access
    input wire logic wr_strobe,
    input wire logic [7:0] wr_data,
    input wire logic rd_strobe,
    output logic [7:0] data_buffer,
    input wire logic irq_clear,
    input wire logic write_collision_flag_clear,
    output var sps_pkg::sps_flags_t flags,
    // Received byte stream
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [7:0] rx_data,
    // Serial pins
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe,
    input wire logic sdi_i,
    output logic sdo_o,
    output logic sdo_oe,
    input wire logic ss_n_i
);
    // ------------------------------------------------------------
    // Pin sampling and mode decode
    // ------------------------------------------------------------
    logic sck_s;
    logic sdi_s;
    logic ss_n_s;
    logic sck_prev;
    logic is_master;
    logic is_slave;
    logic ss_mode;
    logic ss_off;
    logic slv_live;
    sps_sync #(.W(3)) u_sync (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .d({sck_i, sdi_i, ss_n_i}),
        .q({sck_s, sdi_s, ss_n_s})
    );
    always_comb begin
        unique case (cfg.mode)
            `SPS_MODE_DIV4, `SPS_MODE_DIV16, `SPS_MODE_DIV64,
            `SPS_MODE_TMR, `SPS_MODE_RELOAD: is_master = 1'b1;
            default: is_master = 1'b0;
        endcase
    end
    assign ss_mode = (cfg.mode == `SPS_MODE_SLV_SS);
    assign is_slave = ss_mode || (cfg.mode == `SPS_MODE_SLV);
    assign ss_off = is_slave && ss_mode && ss_n_s;
    // Slave logic sees the clock while enabled; in the select mode only while selected
    assign slv_live = cfg.en && is_slave && !ss_off;
    always_ff @(posedge ref_clk) begin
        if (!nrst) sck_prev <= 1'b0;
        else sck_prev <= sck_s;
    end
    // ------------------------------------------------------------
    // Master clock generator
    // ------------------------------------------------------------
    sps_pkg::sps_mst_t state;
    logic [9:0] div;
    logic [9:0] half_len;
    logic [3:0] phase;
    logic half_end;
    logic start;
    logic accept;
    logic fifo_ready;
    always_comb begin
        unique case (cfg.mode)
            `SPS_MODE_DIV16: half_len = `SPS_HALF_DIV16;
            `SPS_MODE_DIV64: half_len = `SPS_HALF_DIV64;
            `SPS_MODE_RELOAD:
                half_len = ({2'b00, cfg.reload} + `SPS_DIV_ONE) << 1;
            default: half_len = `SPS_HALF_DIV4;
        endcase
    end
    // Timer mode toggles once per tick, halving the timer rate
    assign half_end = (state != sps_pkg::SPS_IDLE) &&
        ((cfg.mode == `SPS_MODE_TMR) ? tmr_tick
                                      : (div == half_len - `SPS_DIV_ONE));
    always_ff @(posedge ref_clk) begin
        if (!nrst || state == sps_pkg::SPS_IDLE || half_end) begin
            div <= `SPS_DIV_ZERO;
        end else begin
            div <= div + `SPS_DIV_ONE;
        end
    end
    // Tail half period keeps the clock idle and allows late sampling
    always_ff @(posedge ref_clk) begin
        if (!nrst || !cfg.en || !is_master) begin
            state <= sps_pkg::SPS_IDLE;
            phase <= `SPS_PHASE_ZERO;
        end else begin
            unique case (state)
                sps_pkg::SPS_IDLE: begin
                    phase <= `SPS_PHASE_ZERO;
                    if (start) state <= sps_pkg::SPS_RUN;
                end
                sps_pkg::SPS_RUN: begin
                    if (half_end) begin
                        phase <= phase + `SPS_PHASE_ONE;
                        if (phase == `SPS_LAST_PHASE) begin
                            state <= sps_pkg::SPS_TAIL;
                        end
                    end
                end
                sps_pkg::SPS_TAIL: begin
                    if (half_end) state <= sps_pkg::SPS_IDLE;
                end
                default: state <= sps_pkg::SPS_IDLE;
            endcase
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            sck_o <= 1'b0;
            sck_oe <= 1'b0;
        end else begin
            sck_oe <= cfg.en && is_master;
            if (state == sps_pkg::SPS_IDLE) begin
                sck_o <= cfg.cpol;
            end else if (state == sps_pkg::SPS_RUN && half_end) begin
                sck_o <= !sck_o;
            end
        end
    end
    // ------------------------------------------------------------
    // Edge events
    // ------------------------------------------------------------
    logic lead_ev;
    logic trail_ev;
    logic samp_edge;
    logic out_edge;
    logic late_pend;
    logic late_ev;
    logic shift_ev;
    logic done;
    logic use_late;
    logic [2:0] bitcnt;
    logic mst_tog;
    logic slv_chg;
    logic mst_samp;
    logic samp_d1;
    logic samp_d2;
    // Master edge events come from the generator's own toggles, not from the pin
    assign mst_tog = (state == sps_pkg::SPS_RUN) && half_end;
    assign slv_chg = slv_live && (sck_s != sck_prev);
    always_comb begin
        if (is_master) begin
            lead_ev = mst_tog && (sck_o == cfg.cpol);
            trail_ev = mst_tog && (sck_o != cfg.cpol);
        end else begin
            lead_ev = slv_chg && (sck_prev == cfg.cpol);
            trail_ev = slv_chg && (sck_prev != cfg.cpol);
        end
    end
    assign out_edge = cfg.cke ? trail_ev : lead_ev;
    assign samp_edge = cfg.cke ? lead_ev : trail_ev;
    // End-of-bit sampling exists only for the master
    assign use_late = cfg.sample_phase_bit && is_master;
    assign late_ev = late_pend && half_end;
    // Master samples wait out the input synchroniser, so the bit
    // taken is the one that stood on the pin at the sampling edge
    assign mst_samp = is_master && !use_late && samp_edge;
    always_ff @(posedge ref_clk) begin
        if (!nrst || !cfg.en) begin
            samp_d1 <= 1'b0;
            samp_d2 <= 1'b0;
        end else begin
            samp_d1 <= mst_samp;
            samp_d2 <= samp_d1;
        end
    end
    always_comb begin
        if (use_late) shift_ev = late_ev;
        else if (is_master) shift_ev = samp_d2;
        else shift_ev = samp_edge;
    end
    assign done = shift_ev && (bitcnt == `SPS_LAST_BIT);
    always_ff @(posedge ref_clk) begin
        if (!nrst || state == sps_pkg::SPS_IDLE) begin
            late_pend <= 1'b0;
        end else if (samp_edge && use_late) begin
            late_pend <= 1'b1;
        end else if (late_ev) begin
            late_pend <= 1'b0;
        end
    end
    // ------------------------------------------------------------
    // Shift register and bit counter
    // ------------------------------------------------------------
    logic [7:0] shift_register;
    logic busy;
    // A master stays busy until its delayed last sample is in
    assign busy = is_master ?
        (state != sps_pkg::SPS_IDLE || samp_d1 || samp_d2) :
        (bitcnt != `SPS_BIT_ZERO);
    // A full receive FIFO stalls new exchanges like a busy port
    assign accept = wr_strobe && !flags.write_collision_flag && !busy && fifo_ready;
    assign start = accept && cfg.en && is_master;
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            shift_register <= `SPS_BYTE_ZERO;
        end else if (accept) begin
            shift_register <= wr_data;
        end else if (shift_ev) begin
            shift_register <= {shift_register[6:0], sdi_s};
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!nrst || !cfg.en || ss_off) begin
            bitcnt <= `SPS_BIT_ZERO;
        end else if (shift_ev) begin
            bitcnt <= bitcnt + `SPS_BIT_ONE;
        end
    end
    // ------------------------------------------------------------
    // Data output pin
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            sdo_o <= 1'b0;
        end else if (accept) begin
            sdo_o <= wr_data[7];
        end else if (is_slave && !slv_live) begin
            sdo_o <= shift_register[7];
        end else if (out_edge) begin
            // Received bits move up, so the next group resends them
            // A shift in the same cycle has already moved the bit up
            sdo_o <= shift_ev ? shift_register[6]
                              : shift_register[7];
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            sdo_oe <= 1'b0;
        end else begin
            sdo_oe <= cfg.en && !sdo_disable &&
                (is_master || (is_slave && !ss_off));
        end
    end
    // ------------------------------------------------------------
    // Buffer and flags
    // ------------------------------------------------------------
    logic [7:0] rx_byte;
    assign rx_byte = {shift_register[6:0], sdi_s};
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            data_buffer <= `SPS_BYTE_ZERO;
        end else if (accept) begin
            data_buffer <= wr_data;
        end else if (done && (!flags.bf || cfg.buffer_overwrite_enable)) begin
            data_buffer <= rx_byte;
        end
    end
    // Hardware set wins over the software clear in each flag
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            flags <= '0;
        end else begin
            if (done) flags.bf <= 1'b1;
            else if (rd_strobe) flags.bf <= 1'b0;
            if (done) flags.irq <= 1'b1;
            else if (irq_clear) flags.irq <= 1'b0;
            if (wr_strobe && (busy || !fifo_ready)) flags.write_collision_flag <= 1'b1;
            else if (write_collision_flag_clear) flags.write_collision_flag <= 1'b0;
            flags.busy <= busy;
        end
    end
    sps_fifo #(.W(`SPS_FIFO_W), .D(`SPS_FIFO_D)) u_fifo (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .in_valid(done),
        .in_ready(fifo_ready),
        .in_data(rx_byte),
        .out_valid(rx_valid),
        .out_ready(rx_ready),
        .out_data(rx_data)
    );
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    idle_clock_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (state == sps_pkg::SPS_IDLE) |=> (sck_o == $past(cfg.cpol)))
        else $error("clock not idle between exchanges");
    byte_flags_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        done |=> (flags.bf && flags.irq))
        else $error("flags not set after full byte");
    collision_set_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (wr_strobe && busy) |=> flags.write_collision_flag)
        else $error("collision flag missing");
    collision_block_a: assert property (@(posedge ref_clk)
        disable iff (!nrst)
        (wr_strobe && flags.write_collision_flag && !busy && !shift_ev) |=>
            $stable(shift_register))
        else $error("write accepted while collision flag set");
    read_clear_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (rd_strobe && !done) |=> !flags.bf)
        else $error("read did not clear buffer full");
    master_start_a: assert property (@(posedge ref_clk)
        disable iff (!nrst)
        start |=> (state == sps_pkg::SPS_RUN) ##0
            (shift_register == $past(wr_data)))
        else $error("master write did not start exchange");
    receive_only_a: assert property (@(posedge ref_clk)
        disable iff (!nrst)
        sdo_disable |=> !sdo_oe)
        else $error("data output driven while disabled");
    select_float_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        ss_off |=> !sdo_oe)
        else $error("output driven while deselected");
    select_reset_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        ss_off |=> (bitcnt == `SPS_BIT_ZERO))
        else $error("bit counter not reset on deselect");
    enable_off_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        !cfg.en |=> (state == sps_pkg::SPS_IDLE && bitcnt == `SPS_BIT_ZERO))
        else $error("port active while disabled");
    overwrite_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (done && flags.bf && !cfg.buffer_overwrite_enable && !accept) |=> $stable(data_buffer))
        else $error("unread byte overwritten");
endmodule : sps_port
`default_nettype wire

// ==== tb/sps_peer.sv ====
// Behavioural far-side SPI party for the port bench
`default_nettype none
module sps_peer (
    // Serial lines
    input wire logic sck,
    input wire logic din,
    output logic dout,
    output logic sck_out,
    output logic ss_n,
    // Setup
    input wire logic cpol,
    input wire logic cke,
    input wire logic listen
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] tx = 8'h00;
    logic [7:0] rx = 8'h00;
    logic first = 1'b1;
    logic pat = 1'b0;
    // ----
    // Line behaviour
    // ----
    initial begin
        sck_out = 1'b0;
        ss_n = 1'b1;
    end
    always #50 pat = ~pat;
    // Released line wanders so a stale bit never passes
    assign dout = (listen || !ss_n) ? tx[7] : pat;
    always @(sck) begin
        if (listen || !ss_n) begin
            if ((sck !== cpol) == cke) begin
                rx = {rx[6:0], din};
            end else if (cke || !first) begin
                tx = {tx[6:0], 1'b0};
            end
            if (sck !== cpol) begin
                first = 1'b0;
            end
        end
    end
    task automatic load(input logic [7:0] d);
        tx = d;
        first = 1'b1;
    endtask : load
    // Short frames break the framing on purpose
    task automatic xfer(input logic [7:0] d, input int n);
        load(d);
        ss_n = 1'b0;
        #125;
        for (int i = 0; i < n; i++) begin
            sck_out = ~cpol;
            #62.5;
            sck_out = cpol;
            #62.5;
        end
        #125;
        ss_n = 1'b1;
    endtask : xfer
endmodule : sps_peer
`default_nettype wire

// ==== tb/sps_port_bench.sv ====
// Self-checking bench of the serial port engine
`default_nettype none
module sps_port_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    sps_pkg::sps_cfg_t cfg = '0;
    logic sdo_disable = 1'b0;
    logic tmr_tick = 1'b0;
    logic wr_strobe = 1'b0;
    logic rd_strobe = 1'b0;
    logic irq_clear = 1'b0;
    logic write_collision_flag_clear = 1'b0;
    logic rx_ready = 1'b0;
    logic lis = 1'b0;
    logic pat = 1'b0;
    logic [7:0] wr_data = 8'h00;
    logic [7:0] data_buffer, rx_data;
    logic rx_valid, sck_o, sck_oe, sdo_o, sdo_oe, psck, pdout, pss_n;
    sps_pkg::sps_flags_t flags;
    int n_errors = 0;
    int total_checks = 0;
    int nt, hp;
    int tc = 0;
    logic [7:0] exp_q[$];
    wire logic sck_w = sck_oe ? sck_o : psck;
    wire logic sdo_w = sdo_oe ? sdo_o : pat;
    sps_port DUT (.ref_clk(ref_clk), .nrst(nrst), .cfg(cfg),
        .sdo_disable(sdo_disable), .tmr_tick(tmr_tick),
        .wr_strobe(wr_strobe), .wr_data(wr_data), .rd_strobe(rd_strobe),
        .data_buffer(data_buffer), .irq_clear(irq_clear),
        .write_collision_flag_clear(write_collision_flag_clear), .flags(flags), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_data(rx_data), .sck_i(sck_w),
        .sck_o(sck_o), .sck_oe(sck_oe), .sdi_i(pdout), .sdo_o(sdo_o),
        .sdo_oe(sdo_oe), .ss_n_i(pss_n));
    sps_peer peer (.sck(sck_w), .din(sdo_w), .dout(pdout), .sck_out(psck),
        .ss_n(pss_n), .cpol(cfg.cpol), .cke(cfg.cke), .listen(lis));
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    always #35 pat = ~pat;
    always @(negedge ref_clk) begin
        tc <= (tc == 4) ? 0 : tc + 1;
        tmr_tick <= (tc == 0);
    end
    // ----
    // Tasks
    // ----
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim
    task automatic pulse(ref logic s);
        @(negedge ref_clk);
        s = 1'b1;
        @(negedge ref_clk);
        s = 1'b0;
    endtask : pulse
    task automatic wr(input logic [7:0] d);
        @(negedge ref_clk);
        wr_data = d;
        wr_strobe = 1'b1;
        @(negedge ref_clk);
        wr_strobe = 1'b0;
    endtask : wr
    // Counts clock toggles and the first half period
    task automatic wdone();
        int k;
        logic last;
        k = 0;
        nt = 0;
        hp = 0;
        last = sck_o;
        while ((k < 4 || flags.busy !== 1'b0) && k < 9000) begin
            @(negedge ref_clk);
            k++;
            if (sck_o !== last) begin
                nt++;
                hp = (nt == 1) ? k : (nt == 2) ? k - hp : hp;
            end
            last = sck_o;
        end
        if (k >= 9000) begin
            n_errors++;
            end_sim();
        end
        repeat (4) @(negedge ref_clk);
    endtask : wdone
    task automatic cfgset(input logic [3:0] m, input logic s,
            input logic p, input logic e);
        @(negedge ref_clk);
        cfg.en = 1'b0;
        @(negedge ref_clk);
        cfg.mode = m;
        cfg.sample_phase_bit = s;
        cfg.cpol = p;
        cfg.cke = e;
        @(negedge ref_clk);
        cfg.en = 1'b1;
        repeat (4) @(negedge ref_clk);
    endtask : cfgset
    task automatic mxfer(input logic [7:0] d, input logic [7:0] back);
        peer.load(back);
        lis = 1'b1;
        pulse(rd_strobe);
        pulse(irq_clear);
        check(flags.bf, 1'b0);
        wr(d);
        wdone();
        lis = 1'b0;
        check(nt, 16);
        check(sck_o, cfg.cpol);
        check(sck_oe, 1'b1);
        if (sdo_disable) begin
            check(sdo_oe, 1'b0);
        end else begin
            check(peer.rx, d);
        end
        check(data_buffer, back);
        check(flags.bf, 1'b1);
        check(flags.irq, 1'b1);
        exp_q.push_back(back);
    endtask : mxfer
    task automatic mrun(input logic [3:0] m, input logic s, input logic p,
            input logic e, input int half);
        cfgset(m, s, p, e);
        mxfer(8'hb4, 8'h2d + {4'h0, m});
        check(hp, half);
        $display("test master mode %h done", m);
    endtask : mrun
    task automatic t_collide();
        peer.load(8'h0f);
        lis = 1'b1;
        pulse(rd_strobe);
        wr(8'h81);
        wr(8'h42);
        wdone();
        lis = 1'b0;
        check(flags.write_collision_flag, 1'b1);
        check(peer.rx, 8'h81);
        exp_q.push_back(8'h0f);
        wr(8'h99);
        wdone();
        check(nt, 0);
        check(data_buffer, 8'h0f);
        pulse(write_collision_flag_clear);
        check(flags.write_collision_flag, 1'b0);
        $display("test collision done");
    endtask : t_collide
    task automatic sframe(input logic [7:0] d, input logic [7:0] echo);
        pulse(irq_clear);
        fork
            peer.xfer(d, 8);
            begin
                #600;
                check(sdo_oe, 1'b1);
            end
        join
        repeat (6) @(negedge ref_clk);
        check(peer.rx, echo);
        check(flags.irq, 1'b1);
        exp_q.push_back(d);
    endtask : sframe
    task automatic t_slave();
        cfgset(4'h4, 1'b0, 1'b0, 1'b1);
        check(sck_oe, 1'b0);
        pulse(rd_strobe);
        wr(8'h96);
        sframe(8'h5a, 8'h96);
        check(data_buffer, 8'h5a);
        sframe(8'h11, 8'h5a);
        check(data_buffer, 8'h5a);
        cfg.buffer_overwrite_enable = 1'b1;
        sframe(8'h22, 8'h11);
        check(data_buffer, 8'h22);
        peer.xfer(8'hff, 4);
        repeat (4) @(negedge ref_clk);
        check(sdo_oe, 1'b0);
        sframe(8'hc3, 8'h2f);
        check(data_buffer, 8'hc3);
        $display("test slave done");
    endtask : t_slave
    task automatic t_free_slave();
        cfgset(4'h5, 1'b0, 1'b0, 1'b0);
        pulse(rd_strobe);
        wr(8'h3a);
        sframe(8'h6c, 8'h3a);
        check(data_buffer, 8'h6c);
        $display("test free slave done");
    endtask : t_free_slave
    task automatic t_fifo();
        cfgset(4'h0, 1'b0, 1'b0, 1'b1);
        while (exp_q.size() < 32) begin
            mxfer(8'(exp_q.size()), ~8'(exp_q.size()));
        end
        wr(8'h55);
        wdone();
        check(nt, 0);
        check(flags.write_collision_flag, 1'b1);
        pulse(write_collision_flag_clear);
        foreach (exp_q[i]) begin
            repeat (3) @(negedge ref_clk);
            check(rx_valid, 1'b1);
            check(rx_data, exp_q[i]);
            rx_ready = 1'b1;
            @(negedge ref_clk);
            rx_ready = 1'b0;
        end
        repeat (3) @(negedge ref_clk);
        check(rx_valid, 1'b0);
        $display("test fifo done");
    endtask : t_fifo
    // ----
    // Main sequence
    // ----
    initial begin
        cfg.reload = 8'h03;
        repeat (5) @(negedge ref_clk);
        nrst = 1'b1;
        wr(8'h3c);
        wdone();
        check(nt, 0);
        $display("test disabled done");
        mrun(4'h0, 1'b0, 1'b0, 1'b1, 2);
        mrun(4'h1, 1'b0, 1'b1, 1'b1, 8);
        mrun(4'h2, 1'b0, 1'b0, 1'b0, 32);
        mrun(4'ha, 1'b1, 1'b1, 1'b0, 8);
        mrun(4'h3, 1'b0, 1'b0, 1'b1, 5);
        sdo_disable = 1'b1;
        mxfer(8'h00, 8'h6e);
        sdo_disable = 1'b0;
        t_collide();
        t_slave();
        t_free_slave();
        t_fifo();
        end_sim();
    end
endmodule : sps_port_bench
`default_nettype wire
